/* include/ibs_defines.vh */
// constants for the isp boot and security control block
// assumes an 8-bit sfr bus and a 16-bit nonvolatile access port
// What this block does
// - soft reset when bits 7,1,0 written 1
// - bit 7 reads 1 in forced loader boot
// - bit 4 enables auxiliary ram
// - bit 1 swaps loader and target banks
// - program enable plus idle wake enters isp
// - program enable clear refuses isp operations
// - default boot from main application bank
// - loader boot if p4.3 low or both p2.7 and p2.6 low
// - security register blocked in programming mode
// - programmed security bits cleared only by erase-all
// - security register at ffff of loader bank
// - lock bit protects on-chip code from readout
// - restricted movc from external reads external only
// - movc from internal reads both memories
// - restriction bit 1 means no movc limits
// - encryption bit encodes port 0 data
// - encryption bit cleared only by chip erase
`ifndef IBS_DEFINES_VH
`define IBS_DEFINES_VH

`define IBS_ADDR_CTRL 8'hBF
`define IBS_ADDR_UNLOCK 8'hF6
`define IBS_CTRL_RESET 8'h00
`define IBS_CTRL_WMASK 8'h13

`define IBS_BIT_SWRST 7
`define IBS_BIT_AUXRAM 4
`define IBS_BIT_LDSEL 1
`define IBS_BIT_PROGEN 0

`define IBS_UNLOCK_KEY1 8'h87
`define IBS_UNLOCK_KEY2 8'h59

`define IBS_SEC_ADDR 16'hFFFF
`define IBS_SEC_ERASED 8'hFF
`define IBS_SEC_LOCK 0
`define IBS_SEC_MOVC 1
`define IBS_SEC_ENC 2
`define IBS_SEC_OSC 7

`define IBS_READ_BLANK 8'hFF

`endif

/* src/ibs_unlock.v */
// write-unlock sequencer for the programming control register
// assumes one-cycle write strobes from the sfr bus
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defines.vh"

module ibs_unlock (
    // clock and reset
    input wire clk,
    input wire rst,
    // unlock register writes
    input wire wr,
    input wire [7:0] wdata,
    // state
    output reg open
);

////////////////////////////////////////////////////////////////////////
localparam ST_LOCKED = 3'b001;
localparam ST_HALF = 3'b010;
localparam ST_OPEN = 3'b100;

reg [2:0] state_reg;
reg [2:0] state_next;

always @* begin
    state_next = state_reg;
    if (wr) begin
        case (state_reg)
            ST_LOCKED: begin
                if (wdata == `IBS_UNLOCK_KEY1)
                    state_next = ST_HALF;
            end
            ST_HALF: begin
                if (wdata == `IBS_UNLOCK_KEY2)
                    state_next = ST_OPEN;
                else if (wdata != `IBS_UNLOCK_KEY1)
                    state_next = ST_LOCKED;
            end
            ST_OPEN: begin
                // keys rewritten keep it open; anything else closes
                if (wdata != `IBS_UNLOCK_KEY1 &&
                    wdata != `IBS_UNLOCK_KEY2)
                    state_next = ST_LOCKED;
            end
            default: state_next = ST_LOCKED;
        endcase
    end
end

always @(posedge clk) begin
    if (rst) begin
        state_reg <= ST_LOCKED;
        open <= 1'b0;
    end else begin
        state_reg <= state_next;
        open <= (state_next == ST_OPEN);
    end
end

endmodule
`default_nettype wire

/* src/ibs_boot_strap.v */
// boot strap sampler: picks the boot bank from port pins
// assumes pins are synchronous and rst covers power-on and soft reset
`timescale 1ns/1ps
`default_nettype none

module ibs_boot_strap (
    // clock and reset
    input wire clk,
    input wire rst,
    // strap pins
    input wire p43,
    input wire p27,
    input wire p26,
    // result
    output reg forced_loader_boot
);

////////////////////////////////////////////////////////////////////////
// sampled on every reset cycle, frozen from the release on
always @(posedge clk) begin
    if (rst)
        forced_loader_boot <= ~p43 | (~p27 & ~p26);
end

endmodule
`default_nettype wire

/* src/ibs_top.v */
// in-system programming, forced boot and security control
// assumes a synchronous sfr bus, one-cycle strobes, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ibs_defines.vh"

module ibs_top #(
    parameter [7:0] ENC_KEY = 8'h5A // arbitrary encoding key
) (
    // clock and reset
    input wire MCLK,
    input wire RESETN,
    // sfr bus
    input wire [7:0] SFR_ADDR,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [7:0] SFR_WDATA,
    output reg [7:0] SFR_RDATA,
    output reg SFR_HIT,
    // cpu status and isp operations
    input wire CPU_IDLE,
    input wire WAKE_IRQ,
    input wire ISP_OP_REQ,
    output reg ISP_OP_GRANT,
    output reg ISP_OP_REFUSE,
    output reg ISP_MODE,
    // strap pins
    input wire PIN_P43,
    input wire PIN_P27,
    input wire PIN_P26,
    // system controls
    output reg SYS_RESET_REQ,
    output reg BOOT_FROM_LOADER,
    output reg AUX_RAM_EN,
    output reg LOADER_IN_MAIN,
    output reg OSC_HALF_GAIN,
    // nonvolatile access port
    input wire NV_RD,
    input wire NV_WR,
    input wire NV_ERASE_ALL,
    input wire NV_BANK_LDR,
    input wire [15:0] NV_ADDR,
    input wire [7:0] NV_WDATA,
    input wire [7:0] NV_ARRAY_RDATA,
    output reg [7:0] NV_RDATA,
    output reg NV_BLOCKED,
    // security byte store
    input wire [7:0] SEC_NV_IMAGE,
    output reg SEC_NV_WE,
    output reg [7:0] SEC_NV_WDATA,
    // code read check
    input wire MOVC_REQ,
    input wire MOVC_FROM_EXT,
    input wire MOVC_TO_INT,
    output reg MOVC_GRANT,
    output reg MOVC_DONE,
    // port 0 data
    input wire [7:0] P0_DATA_IN,
    output reg [7:0] P0_DATA_OUT
);

////////////////////////////////////////////////////////////////////////
function movc_allowed;
    input from_ext;
    input to_int;
    input unrestricted;
    begin
        movc_allowed = ~from_ext | unrestricted | ~to_int;
    end
endfunction

////////////////////////////////////////////////////////////////////////
// reset: external pin or the soft reset pulse
reg soft_rst_reg;
wire rst;
wire ctrl_open;
wire forced_boot;

assign rst = ~RESETN | soft_rst_reg;

ibs_unlock u_unlock (
    .clk(MCLK),
    .rst(rst),
    .wr(SFR_WR && SFR_ADDR == `IBS_ADDR_UNLOCK),
    .wdata(SFR_WDATA),
    .open(ctrl_open)
);

ibs_boot_strap u_strap (
    .clk(MCLK),
    .rst(rst),
    .p43(PIN_P43),
    .p27(PIN_P27),
    .p26(PIN_P26),
    .forced_loader_boot(forced_boot)
);

////////////////////////////////////////////////////////////////////////
// control register
reg [7:0] ctrl_reg;
wire ctrl_wr;
wire soft_hit;
wire prog_en;

assign ctrl_wr = SFR_WR && SFR_ADDR == `IBS_ADDR_CTRL && ctrl_open;
assign soft_hit = ctrl_wr && SFR_WDATA[`IBS_BIT_SWRST] &&
    SFR_WDATA[`IBS_BIT_LDSEL] && SFR_WDATA[`IBS_BIT_PROGEN];
assign prog_en = ctrl_reg[`IBS_BIT_PROGEN];

always @(posedge MCLK) begin
    if (rst) begin
        ctrl_reg <= `IBS_CTRL_RESET;
        soft_rst_reg <= 1'b0;
    end else begin
        // reserved bits and bits 3,2 never stored
        if (ctrl_wr)
            ctrl_reg <= SFR_WDATA & `IBS_CTRL_WMASK;
        soft_rst_reg <= soft_hit;
    end
end

////////////////////////////////////////////////////////////////////////
// sfr read port
reg [7:0] rd_mux;

always @* begin
    rd_mux = 8'h00;
    if (SFR_ADDR == `IBS_ADDR_CTRL) begin
        rd_mux = ctrl_reg;
        rd_mux[`IBS_BIT_SWRST] = forced_boot;
    end else if (SFR_ADDR == `IBS_ADDR_UNLOCK) begin
        rd_mux = {7'h00, ctrl_open};
    end
end

always @(posedge MCLK) begin
    if (rst) begin
        SFR_RDATA <= 8'h00;
        SFR_HIT <= 1'b0;
    end else begin
        SFR_RDATA <= SFR_RD ? rd_mux : 8'h00;
        SFR_HIT <= SFR_RD && (SFR_ADDR == `IBS_ADDR_CTRL ||
            SFR_ADDR == `IBS_ADDR_UNLOCK);
    end
end

////////////////////////////////////////////////////////////////////////
// isp mode entry: wake irq in the same cycle as idle, with programming enabled
reg idle_armed_reg;
reg isp_mode_reg;

always @(posedge MCLK) begin
    if (rst) begin
        idle_armed_reg <= 1'b0;
        isp_mode_reg <= 1'b0;
        ISP_MODE <= 1'b0;
        ISP_OP_GRANT <= 1'b0;
        ISP_OP_REFUSE <= 1'b0;
    end else begin
        if (!prog_en) begin
            idle_armed_reg <= 1'b0;
            isp_mode_reg <= 1'b0;
        end else if (CPU_IDLE && WAKE_IRQ) begin
            isp_mode_reg <= 1'b1;
        end else if (CPU_IDLE) begin
            idle_armed_reg <= 1'b1;
        end
        ISP_MODE <= isp_mode_reg;
        // operations run only while idle in isp mode
        ISP_OP_GRANT <= ISP_OP_REQ && prog_en && isp_mode_reg &&
            CPU_IDLE;
        ISP_OP_REFUSE <= ISP_OP_REQ && !(prog_en && isp_mode_reg &&
            CPU_IDLE);
    end
end

////////////////////////////////////////////////////////////////////////
// boot bank and system controls
always @(posedge MCLK) begin
    if (rst) begin
        SYS_RESET_REQ <= 1'b0;
        BOOT_FROM_LOADER <= 1'b0;
        AUX_RAM_EN <= 1'b0;
        LOADER_IN_MAIN <= 1'b1;
    end else begin
        SYS_RESET_REQ <= soft_hit;
        BOOT_FROM_LOADER <= forced_boot;
        AUX_RAM_EN <= ctrl_reg[`IBS_BIT_AUXRAM];
        LOADER_IN_MAIN <= ~ctrl_reg[`IBS_BIT_LDSEL];
    end
end

////////////////////////////////////////////////////////////////////////
// hazard: the image is taken one cycle after the pin reset lifts
reg img_loaded_reg;
always @(posedge MCLK) begin
    if (!RESETN)
        img_loaded_reg <= 1'b0;
    else
        img_loaded_reg <= 1'b1;
end

// one-cycle pulse right after the pin reset: reload the stored byte
reg img_take_reg;
always @(posedge MCLK) begin
    if (!RESETN)
        img_take_reg <= 1'b0;
    else
        img_take_reg <= ~img_loaded_reg;
end

// security byte: nonvolatile, so soft reset reloads the stored image
// soft reset must not erase it, so only the pin reset clears it here
reg [7:0] sec_reg;
wire sec_sel;
wire nv_block;
wire locked;

assign sec_sel = NV_BANK_LDR && NV_ADDR == `IBS_SEC_ADDR;
assign nv_block = isp_mode_reg && sec_sel;
assign locked = ~sec_reg[`IBS_SEC_LOCK];

always @(posedge MCLK) begin
    if (!RESETN) begin
        sec_reg <= `IBS_SEC_ERASED;
        SEC_NV_WE <= 1'b0;
        SEC_NV_WDATA <= `IBS_SEC_ERASED;
    end else if (soft_rst_reg || img_take_reg) begin
        sec_reg <= SEC_NV_IMAGE;
        SEC_NV_WE <= 1'b0;
        SEC_NV_WDATA <= `IBS_SEC_ERASED;
    end else if (NV_ERASE_ALL && !isp_mode_reg) begin
        // only erase-all brings programmed bits back to 1
        sec_reg <= `IBS_SEC_ERASED;
        SEC_NV_WE <= 1'b1;
        SEC_NV_WDATA <= `IBS_SEC_ERASED;
    end else if (NV_WR && sec_sel && !nv_block) begin
        // programming can only pull bits low
        sec_reg <= sec_reg & NV_WDATA;
        SEC_NV_WE <= 1'b1;
        SEC_NV_WDATA <= sec_reg & NV_WDATA;
    end else begin
        SEC_NV_WE <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////
// nonvolatile read path with lock and blocking
always @(posedge MCLK) begin
    if (rst) begin
        NV_RDATA <= 8'h00;
        NV_BLOCKED <= 1'b0;
    end else begin
        NV_BLOCKED <= (NV_RD || NV_WR) && nv_block;
        if (NV_RD) begin
            if (nv_block)
                NV_RDATA <= `IBS_READ_BLANK;
            else if (sec_sel)
                NV_RDATA <= sec_reg;
            else if (locked)
                NV_RDATA <= `IBS_READ_BLANK;
            else
                NV_RDATA <= NV_ARRAY_RDATA;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// code read check, port 0 encoding, oscillator gain
always @(posedge MCLK) begin
    if (rst) begin
        MOVC_GRANT <= 1'b0;
        MOVC_DONE <= 1'b0;
        P0_DATA_OUT <= 8'h00;
        OSC_HALF_GAIN <= 1'b0;
    end else begin
        MOVC_DONE <= MOVC_REQ;
        MOVC_GRANT <= MOVC_REQ && movc_allowed(MOVC_FROM_EXT,
            MOVC_TO_INT, sec_reg[`IBS_SEC_MOVC]);
        if (sec_reg[`IBS_SEC_ENC] == 1'b0)
            P0_DATA_OUT <= P0_DATA_IN ^ ENC_KEY;
        else
            P0_DATA_OUT <= P0_DATA_IN;
        OSC_HALF_GAIN <= ~sec_reg[`IBS_SEC_OSC];
    end
end

endmodule
`default_nettype wire

/* verif/ibs_monitor.sv */
// assertion monitor for the isp boot and security control top
// assumes it is bound to ibs_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module ibs_monitor (
    // clock and reset
    input wire MCLK,
    input wire RESETN,
    // sfr bus
    input wire [7:0] SFR_ADDR,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [7:0] SFR_WDATA,
    input wire [7:0] SFR_RDATA,
    input wire SFR_HIT,
    // isp
    input wire CPU_IDLE,
    input wire WAKE_IRQ,
    input wire ISP_OP_REQ,
    input wire ISP_OP_REFUSE,
    input wire ISP_MODE,
    // system
    input wire SYS_RESET_REQ,
    input wire BOOT_FROM_LOADER,
    input wire AUX_RAM_EN,
    input wire OSC_HALF_GAIN,
    input wire NV_ERASE_ALL,
    // code read
    input wire MOVC_REQ,
    input wire MOVC_FROM_EXT,
    input wire MOVC_GRANT,
    input wire MOVC_DONE
);
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    wire ctl_wr = SFR_WR && SFR_ADDR == 8'hBF;
    wire ctl_rd = SFR_RD && SFR_ADDR == 8'hBF;
    wire wake = CPU_IDLE && WAKE_IRQ;
    ////////////////////////////////////////////////////////////////////
    chk_soft_cause: assert property (
        SYS_RESET_REQ |-> $past(ctl_wr && SFR_WDATA[7] && SFR_WDATA[1]
        && SFR_WDATA[0])) else $error("soft reset without its write");
    chk_soft_clear: assert property (
        SYS_RESET_REQ |-> ##2 (!AUX_RAM_EN && !ISP_MODE))
        else $error("state kept over soft reset");
    chk_mode_read: assert property (
        $past(ctl_rd) && $past(RESETN) |-> SFR_HIT
        && SFR_RDATA[7] == BOOT_FROM_LOADER && SFR_RDATA[4] == AUX_RAM_EN)
        else $error("control read disagrees with state");
    chk_isp_entry: assert property (
        $rose(ISP_MODE) |-> $past(wake) || $past(wake, 2))
        else $error("isp mode without idle wake");
    chk_isp_refuse: assert property (
        ISP_OP_REQ && !CPU_IDLE |=> ISP_OP_REFUSE)
        else $error("isp request outside idle not refused");
    chk_osc_fall: assert property (
        $fell(OSC_HALF_GAIN) |-> $past(NV_ERASE_ALL)
        || $past(NV_ERASE_ALL, 2) || $past(SYS_RESET_REQ)
        || $past(SYS_RESET_REQ, 2)) else $error("security bit came back");
    chk_movc_internal: assert property (
        MOVC_REQ && !MOVC_FROM_EXT |=> MOVC_DONE && MOVC_GRANT)
        else $error("internal code read refused");
    // straps settle one edge after any reset, so skip those edges
    chk_boot_hold: assert property (
        $past(RESETN) && $past(RESETN, 2) && !$past(SYS_RESET_REQ)
        && !$past(SYS_RESET_REQ, 2) && !$past(SYS_RESET_REQ, 3)
        |-> $stable(BOOT_FROM_LOADER)) else $error("boot bank moved");
    cov_soft: cover property (SYS_RESET_REQ);
    cov_isp: cover property (ISP_MODE && ISP_OP_REQ && CPU_IDLE);
    cov_osc: cover property ($fell(OSC_HALF_GAIN));
endmodule
////////////////////////////////////////////////////////////////////////
bind ibs_top ibs_monitor ibs_monitor_inst (.MCLK(MCLK), .RESETN(RESETN),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
    .CPU_IDLE(CPU_IDLE), .WAKE_IRQ(WAKE_IRQ), .ISP_OP_REQ(ISP_OP_REQ),
    .ISP_OP_REFUSE(ISP_OP_REFUSE), .ISP_MODE(ISP_MODE),
    .SYS_RESET_REQ(SYS_RESET_REQ), .BOOT_FROM_LOADER(BOOT_FROM_LOADER),
    .AUX_RAM_EN(AUX_RAM_EN), .OSC_HALF_GAIN(OSC_HALF_GAIN),
    .NV_ERASE_ALL(NV_ERASE_ALL), .MOVC_REQ(MOVC_REQ),
    .MOVC_FROM_EXT(MOVC_FROM_EXT), .MOVC_GRANT(MOVC_GRANT),
    .MOVC_DONE(MOVC_DONE));
`default_nettype wire

/* verif/tb_isp_boot_security_control.sv */
// self-checking bench for the isp boot and security control top
// assumes ibs_top and the bound monitor are compiled before it
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module tb_isp_boot_security_control;
    localparam logic [7:0] KEY = 8'hC3;
    typedef struct {logic ext; logic tint; logic [7:0] din; logic g;} ibs_row_t;
    // restricted grant column; unrestricted always grants
    ibs_row_t rows [4] = '{'{0, 0, 8'h00, 1}, '{0, 1, 8'hFF, 1},
        '{1, 0, 8'hA5, 1}, '{1, 1, 8'h3C, 0}};
    logic MCLK = 0, RESETN = 0, SFR_WR = 0, SFR_RD = 0, CPU_IDLE = 0;
    logic WAKE_IRQ = 0, ISP_OP_REQ = 0, PIN_P43 = 1, PIN_P27 = 1;
    logic PIN_P26 = 1, NV_RD = 0, NV_WR = 0, NV_ERASE_ALL = 0;
    logic NV_BANK_LDR = 0, MOVC_REQ = 0, MOVC_FROM_EXT = 0, MOVC_TO_INT = 0;
    logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, NV_WDATA = 8'h00;
    logic [7:0] NV_ARRAY_RDATA = 8'h3C, P0_DATA_IN = 8'h00;
    logic [7:0] SEC_NV_IMAGE = 8'hFF;
    logic [15:0] NV_ADDR = 16'h0000;
    logic [7:0] SFR_RDATA, NV_RDATA, SEC_NV_WDATA, P0_DATA_OUT;
    logic SFR_HIT, ISP_OP_GRANT, ISP_OP_REFUSE, ISP_MODE, SYS_RESET_REQ;
    logic BOOT_FROM_LOADER, AUX_RAM_EN, LOADER_IN_MAIN, OSC_HALF_GAIN;
    logic NV_BLOCKED, SEC_NV_WE, MOVC_GRANT, MOVC_DONE;
    int bad_count = 0;
    int total_checks = 0;
    always #2.5 MCLK = ~MCLK;
    ibs_top #(.ENC_KEY(KEY)) ibs_top_inst (.MCLK(MCLK), .RESETN(RESETN),
        .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
        .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
        .CPU_IDLE(CPU_IDLE), .WAKE_IRQ(WAKE_IRQ), .ISP_OP_REQ(ISP_OP_REQ),
        .ISP_OP_GRANT(ISP_OP_GRANT), .ISP_OP_REFUSE(ISP_OP_REFUSE),
        .ISP_MODE(ISP_MODE), .PIN_P43(PIN_P43), .PIN_P27(PIN_P27),
        .PIN_P26(PIN_P26), .SYS_RESET_REQ(SYS_RESET_REQ),
        .BOOT_FROM_LOADER(BOOT_FROM_LOADER), .AUX_RAM_EN(AUX_RAM_EN),
        .LOADER_IN_MAIN(LOADER_IN_MAIN), .OSC_HALF_GAIN(OSC_HALF_GAIN),
        .NV_RD(NV_RD), .NV_WR(NV_WR), .NV_ERASE_ALL(NV_ERASE_ALL),
        .NV_BANK_LDR(NV_BANK_LDR), .NV_ADDR(NV_ADDR), .NV_WDATA(NV_WDATA),
        .NV_ARRAY_RDATA(NV_ARRAY_RDATA), .NV_RDATA(NV_RDATA),
        .NV_BLOCKED(NV_BLOCKED), .SEC_NV_IMAGE(SEC_NV_IMAGE),
        .SEC_NV_WE(SEC_NV_WE), .SEC_NV_WDATA(SEC_NV_WDATA),
        .MOVC_REQ(MOVC_REQ), .MOVC_FROM_EXT(MOVC_FROM_EXT),
        .MOVC_TO_INT(MOVC_TO_INT), .MOVC_GRANT(MOVC_GRANT),
        .MOVC_DONE(MOVC_DONE), .P0_DATA_IN(P0_DATA_IN),
        .P0_DATA_OUT(P0_DATA_OUT));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset(input logic [2:0] pins);
        @(negedge MCLK);
        RESETN = 0;
        {PIN_P43, PIN_P27, PIN_P26} = pins;
        repeat (16) @(negedge MCLK);
        RESETN = 1;
        repeat (2) @(negedge MCLK);
    endtask
    // results are read by the caller at the negedge after the answer
    task automatic sfr(input logic w, input logic [7:0] a, d);
        @(negedge MCLK);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = w;
        SFR_RD = !w;
        @(negedge MCLK);
        SFR_WR = 0;
        SFR_RD = 0;
    endtask
    task automatic nv(input logic [2:0] op, input logic [15:0] a, d);
        @(negedge MCLK);
        {NV_RD, NV_WR, NV_ERASE_ALL} = op;
        NV_BANK_LDR = &a;
        NV_ADDR = a;
        NV_WDATA = d[7:0];
        @(negedge MCLK);
        {NV_RD, NV_WR, NV_ERASE_ALL} = 3'h0;
    endtask
    task automatic isp_req(input logic g);
        @(negedge MCLK);
        ISP_OP_REQ = 1;
        @(negedge MCLK);
        ISP_OP_REQ = 0;
        chk("isp grant", ISP_OP_GRANT, g);
        chk("isp refuse", ISP_OP_REFUSE, !g);
    endtask
    task automatic run_rows(input logic locked);
        foreach (rows[i]) begin
            @(negedge MCLK);
            MOVC_REQ = 1;
            MOVC_FROM_EXT = rows[i].ext;
            MOVC_TO_INT = rows[i].tint;
            P0_DATA_IN = rows[i].din;
            @(negedge MCLK);
            MOVC_REQ = 0;
            chk("movc grant", MOVC_GRANT, locked ? rows[i].g : 1);
            chk("port0", P0_DATA_OUT, rows[i].din ^ (locked ? KEY : 0));
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8000) @(posedge MCLK);
        bad_count++;
        complete_run;
    end
    initial begin
        do_reset(3'h6);
        chk("boot", BOOT_FROM_LOADER, 0);
        run_rows(0);
        sfr(0, 8'h30, 8'h00);
        chk("unmapped hit", SFR_HIT, 0);
        sfr(1, 8'hBF, 8'h13);
        sfr(0, 8'hBF, 8'h00);
        chk("locked ctrl", SFR_RDATA, 8'h00);
        chk("ctrl hit", SFR_HIT, 1);
        sfr(1, 8'hF6, 8'h87);
        sfr(1, 8'hF6, 8'h59);
        sfr(1, 8'hBF, 8'h13);
        sfr(0, 8'hBF, 8'h00);
        chk("ctrl", SFR_RDATA, 8'h13);
        chk("aux ram", AUX_RAM_EN, 1);
        chk("loader main", LOADER_IN_MAIN, 0);
        isp_req(0);
        CPU_IDLE = 1;
        WAKE_IRQ = 1;
        @(negedge MCLK);
        WAKE_IRQ = 0;
        repeat (2) @(negedge MCLK);
        chk("isp mode", ISP_MODE, 1);
        isp_req(1);
        nv(3'h4, 16'hFFFF, 8'h00);
        chk("blocked", NV_BLOCKED, 1);
        chk("blocked data", NV_RDATA, 8'hFF);
        sfr(1, 8'hBF, 8'h12);
        @(negedge MCLK);
        isp_req(0);
        CPU_IDLE = 0;
        PIN_P43 = 0;
        sfr(1, 8'hBF, 8'h83);
        for (int k = 0; k < 4 && !SYS_RESET_REQ; k++)
            @(negedge MCLK);
        chk("soft reset", SYS_RESET_REQ, 1);
        repeat (3) @(negedge MCLK);
        PIN_P43 = 1;
        sfr(1, 8'hBF, 8'h13);
        sfr(0, 8'hBF, 8'h00);
        chk("ctrl after soft", SFR_RDATA, 8'h80);
        chk("boot pinned", BOOT_FROM_LOADER, 1);
        nv(3'h2, 16'hFFFF, 8'h78);
        chk("sec we", SEC_NV_WE, 1);
        nv(3'h2, 16'hFFFF, 8'hFF);
        chk("sec data", SEC_NV_WDATA, 8'h78);
        @(negedge MCLK);
        chk("half gain", OSC_HALF_GAIN, 1);
        nv(3'h4, 16'hFFFF, 8'h00);
        chk("sec read", NV_RDATA, 8'h78);
        nv(3'h4, 16'h0123, 8'h00);
        chk("locked array", NV_RDATA, 8'hFF);
        run_rows(1);
        nv(3'h1, 16'h0000, 8'h00);
        @(negedge MCLK);
        chk("gain after erase", OSC_HALF_GAIN, 0);
        nv(3'h4, 16'h0123, 8'h00);
        chk("open array", NV_RDATA, 8'h3C);
        run_rows(0);
        do_reset(3'h4);
        chk("boot p2 pins", BOOT_FROM_LOADER, 1);
        do_reset(3'h5);
        chk("boot one pin", BOOT_FROM_LOADER, 0);
        complete_run;
    end
endmodule
`default_nettype wire
